// ==== dvs_regs.svh ====
// constants of the video packet sequencer: packet codes, hold lengths, frame layout
// assumes inclusion by bare name from the package and the sequencer files
`ifndef DVS_REGS_SVH
`define DVS_REGS_SVH

// ----------------------------------------------------------------
// short packet identifiers and header check bytes
// ----------------------------------------------------------------
`define DVS_DI_VSS      8'h01
`define DVS_ECC_VSS     8'h07
`define DVS_DI_VSE      8'h11
`define DVS_ECC_VSE     8'h14
`define DVS_DI_HSS      8'h21
`define DVS_ECC_HSS     8'h12
`define DVS_DI_HSE      8'h31
`define DVS_ECC_HSE     8'h01
`define DVS_DI_EOT      8'h08
`define DVS_EOT_PAY     16'h0f0f
`define DVS_ECC_EOT     8'h01

// ----------------------------------------------------------------
// long packets
// ----------------------------------------------------------------
`define DVS_DT_PIX      8'h0e
`define DVS_DT_BLANK    8'h19
`define DVS_BL20_WC     16'h0014
`define DVS_BL20_ECC    8'h1f
`define DVS_CRC_INIT    16'hffff
`define DVS_CRC_POLY    16'h8408
`define DVS_LONG_OVHD   16'h0006

// ----------------------------------------------------------------
// low-power holds in unit intervals, and in byte slots of 8 intervals
// ----------------------------------------------------------------
`define DVS_UI_PER_SLOT 8
`define DVS_HOLD_A_UI   12736
`define DVS_HOLD_V_UI   960
`define DVS_HOLD_B_UI   13728
`define DVS_HOLD_A_SLOT (`DVS_HOLD_A_UI / `DVS_UI_PER_SLOT)
`define DVS_HOLD_V_SLOT (`DVS_HOLD_V_UI / `DVS_UI_PER_SLOT)
`define DVS_HOLD_B_SLOT (`DVS_HOLD_B_UI / `DVS_UI_PER_SLOT)

// ----------------------------------------------------------------
// frame layout in lines, counted from the first blanking line
// ----------------------------------------------------------------
`define DVS_LINE_VSS    10'd9
`define DVS_LINE_VSE    10'd15
`define DVS_LINE_VID0   10'd45
`define DVS_LINE_LAST   10'd524

`endif

// ==== dvs_pkg.sv ====
// types shared by the video packet sequencer files
// assumes dvs_regs.svh sits in the include path
package dvs_pkg;
  `include "dvs_regs.svh"

  typedef enum logic [1:0] {
    DVS_MODE_PULSE,
    DVS_MODE_EVENT,
    DVS_MODE_BURST
  } dvs_mode_type;

  typedef enum logic [3:0] {
    DVS_ST_INIT,
    DVS_ST_SHORT1,
    DVS_ST_EOT1,
    DVS_ST_HOLD1,
    DVS_ST_LHDR,
    DVS_ST_LPAY,
    DVS_ST_LCRC,
    DVS_ST_SHORT2,
    DVS_ST_EOT2,
    DVS_ST_HOLD2
  } dvs_state_type;

  typedef enum logic [1:0] {
    DVS_LK_FILL,
    DVS_LK_PIX,
    DVS_LK_BL20
  } dvs_long_type;
endpackage : dvs_pkg

// ==== dvs_crc16.sv ====
// payload checksum: 16-bit crc, reflected, one byte per enabled cycle
// assumes the caller clears it before the first payload byte
`timescale 1ns/1ps
`include "dvs_regs.svh"
module dvs_crc16 (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  din,
  // running value
  output logic      [15:0] crc
);
  import dvs_pkg::*;

  function automatic logic [15:0] dvs_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `DVS_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : dvs_crc_byte

  // empty payload leaves the all-ones start value
  always_ff @(posedge core_clk) begin
    if (!rstn || clr) begin
      crc <= `DVS_CRC_INIT;
    end else if (en) begin
      crc <= dvs_crc_byte(crc, din);
    end
  end
endmodule : dvs_crc16

// ==== dvs_slot_timer.sv ====
// down-counter of byte slots for timed low-power holds
// assumes tick is a one-cycle pulse per link byte slot
`timescale 1ns/1ps
module dvs_slot_timer (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // control
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        tick,
  // status
  output logic             done
);
  logic [15:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (tick && cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // done must not look at load: the sequencer derives load from done, which would close a loop
  assign done = cnt_reg == 16'h0000;
endmodule : dvs_slot_timer

// ==== dvs_sequencer.sv ====
// top of the video packet sequencer: emits the byte stream of a frame
// assumes link_clk is the free-running byte slot clock of the lane, asynchronous
`timescale 1ns/1ps
`include "dvs_regs.svh"
module dvs_sequencer #(
  parameter logic [15:0] PIX_WC     = 16'h05a0,
  parameter logic [7:0]  PIX_ECC    = 8'h08,
  parameter logic [7:0]  FILL_ECC_A = 8'h00,
  parameter logic [7:0]  FILL_ECC_V = 8'h00
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // link slot clock
  input  wire logic                  link_clk,
  // configuration
  input  wire dvs_pkg::dvs_mode_type video_mode,
  input  wire logic                  fill_en,
  // pixel feed
  input  wire logic [7:0]            pix_byte,
  input  wire logic                  pix_valid,
  output logic                       pix_ready,
  // lane byte stream
  output logic [7:0]                 tx_byte,
  output logic                       tx_stb,
  output logic                       tx_hs,
  output logic                       tx_lp11,
  output logic                       frame_start,
  // returned long packet footer check
  input  wire logic                  rx_footer_stb,
  input  wire logic [15:0]           rx_footer,
  input  wire logic [15:0]           rx_crc_calc,
  input  wire logic                  periph_crc_en,
  output logic                       rx_crc_err
);
  import dvs_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (`DVS_HOLD_V_SLOT < `DVS_LONG_OVHD) begin : g_bad_hold
    $error("hold too short to carry a blanking fill packet");
  end
  if (PIX_WC == 16'h0000) begin : g_bad_wc
    $error("pixel packet needs a non-empty payload");
  end

  // ----------------------------------------------------------------
  // link slot edge: two flops, then edge detect on the second
  // ----------------------------------------------------------------
  logic lk_s1_reg, lk_s2_reg, lk_s3_reg, slot;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lk_s1_reg <= 1'b0;
      lk_s2_reg <= 1'b0;
      lk_s3_reg <= 1'b0;
    end else begin
      lk_s1_reg <= link_clk;
      lk_s2_reg <= lk_s1_reg;
      lk_s3_reg <= lk_s2_reg;
    end
  end
  assign slot = lk_s2_reg && !lk_s3_reg;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dvs_state_type state_reg, state_next;
  dvs_long_type  lkind_reg, lkind_next;
  logic [15:0]   bcnt_reg, l_wc, crc, hold_val;
  logic [9:0]    line_reg;
  logic [7:0]    byte_mux, s2_di, s2_ecc, l_di, l_ecc;
  logic          step, last, emit, hold_done, hold_load, is_video, is_event;

  assign is_video = line_reg >= `DVS_LINE_VID0;
  assign is_event = video_mode == DVS_MODE_EVENT;
  assign step = slot || (video_mode == DVS_MODE_BURST && state_reg == DVS_ST_LPAY
                         && lkind_reg == DVS_LK_PIX);

  always_comb begin
    if (line_reg == `DVS_LINE_VSS) begin
      s2_di  = `DVS_DI_VSS;
      s2_ecc = `DVS_ECC_VSS;
    end else if (line_reg == `DVS_LINE_VSE && !is_event) begin
      s2_di  = `DVS_DI_VSE;
      s2_ecc = `DVS_ECC_VSE;
    end else begin
      s2_di  = `DVS_DI_HSS;
      s2_ecc = `DVS_ECC_HSS;
    end
  end

  always_comb begin
    case (lkind_reg)
      DVS_LK_PIX: begin
        l_di  = `DVS_DT_PIX;
        l_wc  = PIX_WC;
        l_ecc = PIX_ECC;
      end
      DVS_LK_BL20: begin
        l_di  = `DVS_DT_BLANK;
        l_wc  = `DVS_BL20_WC;
        l_ecc = `DVS_BL20_ECC;
      end
      default: begin
        l_di  = `DVS_DT_BLANK;
        l_wc  = is_video ? 16'(`DVS_HOLD_V_SLOT) - `DVS_LONG_OVHD : 16'(`DVS_HOLD_A_SLOT) - `DVS_LONG_OVHD;
        l_ecc = is_video ? FILL_ECC_V : FILL_ECC_A;
      end
    endcase
  end

  // byte selection per state
  always_comb begin
    emit     = 1'b1;
    last     = bcnt_reg == 16'h0003;
    byte_mux = 8'h00;
    case (state_reg)
      DVS_ST_SHORT1: byte_mux = bcnt_reg[1:0] == 2'd0 ? `DVS_DI_HSE :
                                bcnt_reg[1:0] == 2'd3 ? `DVS_ECC_HSE : 8'h00;
      DVS_ST_SHORT2: byte_mux = bcnt_reg[1:0] == 2'd0 ? s2_di :
                                bcnt_reg[1:0] == 2'd3 ? s2_ecc : 8'h00;
      DVS_ST_EOT1, DVS_ST_EOT2: byte_mux = bcnt_reg[1:0] == 2'd0 ? `DVS_DI_EOT :
                                           bcnt_reg[1:0] == 2'd3 ? `DVS_ECC_EOT : 8'(`DVS_EOT_PAY);
      DVS_ST_LHDR: byte_mux = bcnt_reg[1:0] == 2'd0 ? l_di :
                              bcnt_reg[1:0] == 2'd1 ? l_wc[7:0] :
                              bcnt_reg[1:0] == 2'd2 ? l_wc[15:8] : l_ecc;
      DVS_ST_LPAY: begin
        // payload length from word count; blank payload is zero
        last     = bcnt_reg == l_wc - 16'h0001;
        emit     = lkind_reg != DVS_LK_PIX || pix_valid;
        byte_mux = lkind_reg == DVS_LK_PIX ? pix_byte : 8'h00;
      end
      DVS_ST_LCRC: begin
        last     = bcnt_reg == 16'h0001;
        byte_mux = bcnt_reg[0] ? crc[15:8] : crc[7:0];
      end
      default: emit = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    state_next = state_reg;
    lkind_next = lkind_reg;
    hold_load  = 1'b0;
    hold_val   = 16'(`DVS_HOLD_B_SLOT);
    case (state_reg)
      DVS_ST_INIT: if (hold_done) begin
        state_next = is_event ? DVS_ST_HOLD1 : DVS_ST_SHORT1;
        hold_load  = is_event;
        hold_val   = is_video ? 16'(`DVS_HOLD_V_SLOT) : 16'(`DVS_HOLD_A_SLOT);
      end
      DVS_ST_SHORT1: if (step && last) begin
        // fill keeps the burst open, so no end packet yet
        if (fill_en && video_mode == DVS_MODE_PULSE) begin
          state_next = DVS_ST_LHDR;
          lkind_next = DVS_LK_FILL;
        end else begin
          state_next = DVS_ST_EOT1;
        end
      end
      DVS_ST_EOT1: if (step && last) begin
        // timed low-power instead of a blank packet
        state_next = DVS_ST_HOLD1;
        hold_load  = 1'b1;
        hold_val   = is_video ? 16'(`DVS_HOLD_V_SLOT) : 16'(`DVS_HOLD_A_SLOT);
      end
      DVS_ST_HOLD1: if (hold_done) begin
        state_next = is_video ? DVS_ST_LHDR : DVS_ST_SHORT2;
        lkind_next = DVS_LK_PIX;
      end
      DVS_ST_LHDR: if (step && last) begin
        state_next = l_wc == 16'h0000 ? DVS_ST_LCRC : DVS_ST_LPAY;
      end
      DVS_ST_LPAY: if (step && emit && last) begin
        state_next = DVS_ST_LCRC;
      end
      // footer only after long packets; fill, pixels, blank in one burst
      DVS_ST_LCRC: if (step && last) begin
        if (lkind_reg == DVS_LK_PIX) begin
          state_next = DVS_ST_LHDR;
          lkind_next = DVS_LK_BL20;
        end else if (lkind_reg == DVS_LK_FILL && is_video) begin
          state_next = DVS_ST_LHDR;
          lkind_next = DVS_LK_PIX;
        end else begin
          state_next = DVS_ST_SHORT2;
        end
      end
      DVS_ST_SHORT2: if (step && last) begin
        state_next = DVS_ST_EOT2;
      end
      // every line drops to low power
      DVS_ST_EOT2: if (step && last) begin
        state_next = DVS_ST_HOLD2;
        hold_load  = 1'b1;
      end
      DVS_ST_HOLD2: if (hold_done) begin
        // event mode skips the end event
        state_next = is_event ? DVS_ST_HOLD1 : DVS_ST_SHORT1;
        hold_load  = is_event;
        hold_val   = (line_reg + 10'd1 >= `DVS_LINE_VID0 && line_reg != `DVS_LINE_LAST)
                     ? 16'(`DVS_HOLD_V_SLOT) : 16'(`DVS_HOLD_A_SLOT);
      end
      default: state_next = DVS_ST_INIT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= DVS_ST_INIT;
      lkind_reg <= DVS_LK_PIX;
      line_reg  <= 10'd0;
    end else begin
      state_reg <= state_next;
      lkind_reg <= lkind_next;
      if (state_reg == DVS_ST_HOLD2 && hold_done) begin
        line_reg <= line_reg == `DVS_LINE_LAST ? 10'd0 : line_reg + 10'd1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || state_next != state_reg || lkind_next != lkind_reg) begin
      bcnt_reg <= 16'h0000;
    end else if (step && emit) begin
      bcnt_reg <= bcnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_byte     <= 8'h00;
      tx_stb      <= 1'b0;
      tx_hs       <= 1'b0;
      tx_lp11     <= 1'b1;
      pix_ready   <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      tx_stb      <= step && emit;
      if (step && emit) begin
        tx_byte <= byte_mux;
      end
      // holds keep LP-11; lags the state so the last strobed byte still goes out in hs
      tx_lp11     <= state_reg == DVS_ST_INIT || state_reg == DVS_ST_HOLD1
                     || state_reg == DVS_ST_HOLD2;
      tx_hs       <= !(state_reg == DVS_ST_INIT || state_reg == DVS_ST_HOLD1
                       || state_reg == DVS_ST_HOLD2);
      pix_ready   <= state_next == DVS_ST_LPAY && lkind_next == DVS_LK_PIX
                     && !(state_reg == DVS_ST_LPAY && step && emit && last);
      frame_start <= state_reg == DVS_ST_SHORT2 && line_reg == `DVS_LINE_VSS && bcnt_reg == 16'h0000 && step;
    end
  end

  // skip check for peripherals without checksum; their footer is 0000
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_crc_err <= 1'b0;
    end else begin
      rx_crc_err <= rx_footer_stb && periph_crc_en && rx_footer != rx_crc_calc;
    end
  end

  dvs_crc16 u_crc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clr      (state_reg == DVS_ST_LHDR),
    .en       (state_reg == DVS_ST_LPAY && step && emit),
    .din      (byte_mux),
    .crc      (crc)
  );

  dvs_slot_timer u_hold (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (hold_load || (state_reg == DVS_ST_INIT && !rstn)),
    .load_val (hold_val),
    .tick     (slot),
    .done     (hold_done)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_eot_start;
    state_reg == DVS_ST_EOT2 && bcnt_reg == 16'h0000 && step;
  endsequence
  sequence s_lp_after;
    tx_lp11 && !tx_hs;
  endsequence

  chk_eot_first: assert property (s_eot_start |=> tx_stb && tx_byte == 8'h08) else $error("eot id wrong");
  chk_eot_lp: assert property (state_reg == DVS_ST_EOT2 && step && last |=> ##1 s_lp_after) else $error("no lp");
  chk_hse_id: assert property (state_reg == DVS_ST_SHORT1 && bcnt_reg == 16'h0000 && step
                               |=> tx_byte == 8'h31) else $error("hse id wrong");
  chk_hse_ecc: assert property (state_reg == DVS_ST_SHORT1 && last && step |=> tx_byte == 8'h01)
    else $error("hse ecc wrong");
  chk_opener_vss: assert property (state_reg == DVS_ST_SHORT2 && line_reg == `DVS_LINE_VSS
                                   && bcnt_reg == 16'h0000 && step |=> tx_byte == 8'h01 && frame_start)
    else $error("vss opener wrong");
  chk_crc_low: assert property (state_reg == DVS_ST_LCRC && bcnt_reg == 16'h0000 && step
                                |=> tx_byte == crc[7:0]) else $error("crc order wrong");
  chk_crc_empty: assert property (state_reg == DVS_ST_LHDR && l_wc == 16'h0000 && last && step
                                  |=> ##[1:20] (tx_stb && tx_byte == 8'hff)) else $error("empty crc wrong");
  chk_hold_lp11: assert property (state_reg == DVS_ST_HOLD2 |=> tx_lp11 && !tx_hs) else $error("hold not lp11");
  chk_no_footer: assert property (state_reg == DVS_ST_SHORT2 |=> state_reg != DVS_ST_LCRC)
    else $error("footer after short");
  chk_line_wrap: assert property (line_reg == `DVS_LINE_LAST && state_reg == DVS_ST_HOLD2 && hold_done
                                  |=> line_reg == 10'd0) else $error("frame wrap wrong");
endmodule : dvs_sequencer

// ==== dvs_periph_model.sv ====
// far-side display peripheral: returns long packet footers to the host checker
// assumes the bench raises send for one cycle just after a falling edge
`timescale 1ns/1ps
module dvs_periph_model (
  // clock
  input  wire logic        core_clk,
  // request from the bench
  input  wire logic        send,
  input  wire logic        crc_cap,
  input  wire logic        corrupt,
  input  wire logic [15:0] value,
  // footer toward the host
  output logic             rx_footer_stb,
  output logic [15:0]      rx_footer,
  output logic [15:0]      rx_crc_calc,
  output logic             periph_crc_en
);
  initial begin
    rx_footer_stb = 1'b0;
    rx_footer     = 16'h0000;
    rx_crc_calc   = 16'h0000;
    periph_crc_en = 1'b0;
  end
  always @(posedge core_clk) begin
    if (send) begin
      rx_footer_stb <= 1'b1;
      rx_crc_calc   <= value;
      periph_crc_en <= crc_cap;
      rx_footer     <= crc_cap ? (value ^ {15'h0000, corrupt}) : 16'h0000;
    end else if (rx_footer_stb) begin
      rx_footer_stb <= 1'b0;
      // released footer and checksum lines never keep the last value
      rx_footer     <= ~rx_footer;
      rx_crc_calc   <= ~rx_crc_calc;
    end
  end
endmodule : dvs_periph_model

// ==== dvs_sequencer_bench.sv ====
// self-checking bench of the video packet sequencer: byte stream and footer check
// assumes dvs_pkg and dvs_periph_model are compiled before it
`timescale 1ns/1ps
module dvs_sequencer_bench;
  import dvs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic         core_clk = 1'b0, rstn = 1'b0, link_clk = 1'b0;
  dvs_mode_type video_mode = DVS_MODE_BURST;
  logic         fill_en = 1'b0, pix_valid = 1'b0, send = 1'b0, crc_cap = 1'b0, corrupt = 1'b0;
  logic [7:0]   pix_byte = 8'h00, tx_byte;
  logic [15:0]  value = 16'h0000, rx_footer, rx_crc_calc, crc = 16'hffff;
  logic         pix_ready, tx_stb, tx_hs, tx_lp11, frame_start, rx_footer_stb, periph_crc_en, rx_crc_err;
  int           num_errors = 0, n_compared = 0, n_bytes = 0, lp_cnt = 0, seed = 83433, v, lp;
  int           exp_q[$], lp_q[$];

  dvs_sequencer #(.FILL_ECC_A(8'h5a)) i_dvs_sequencer (.core_clk, .rstn, .link_clk, .video_mode,
    .fill_en, .pix_byte, .pix_valid, .pix_ready, .tx_byte, .tx_stb, .tx_hs, .tx_lp11, .frame_start,
    .rx_footer_stb, .rx_footer, .rx_crc_calc, .periph_crc_en, .rx_crc_err);
  dvs_periph_model i_dvs_periph_model (.core_clk, .send, .crc_cap, .corrupt, .value,
    .rx_footer_stb, .rx_footer, .rx_crc_calc, .periph_crc_en);

  // ----------------------------------------------------------------
  // clocks: link slot clock offset so its edges never meet core edges
  // ----------------------------------------------------------------
  always #50 core_clk = ~core_clk;
  initial begin
    #37;
    forever #400 link_clk = ~link_clk;
  end
  always @(negedge core_clk) begin
    pix_byte  <= 8'($random(seed));
    pix_valid <= 1'($random(seed));
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // lp is the low-power slot count expected before the first byte, -1 unchecked
  task automatic push4(input logic [31:0] w, input int lp0);
    for (int i = 3; i >= 0; i--) begin
      exp_q.push_back(int'(w[8*i+:8]));
      lp_q.push_back(i == 3 ? lp0 : 0);
    end
  endtask : push4

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    return c;
  endfunction : crc_step

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // monitor: oldest note against every strobed byte
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (tx_lp11 === 1'b1)
      lp_cnt++;
    if (tx_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare byte", {8'h00, tx_byte}, 16'h0100);
      end else begin
        v  = exp_q.pop_front();
        lp = lp_q.pop_front();
        // slot rounding absorbs the synchroniser phase
        if (lp >= 0) check("low-power slots", 16'((lp_cnt + 4) / 8), 16'(lp));
        check("hs at byte", {15'h0000, tx_hs}, 16'h0001);
        check("frame start", {15'h0000, frame_start}, 16'h0000);
        check("pixel ready", {15'h0000, pix_ready}, 16'h0000);
        if (v == -1) crc = crc_step(crc, tx_byte);
        else if (v == -2) check("crc low", {8'h00, tx_byte}, {8'h00, crc[7:0]});
        else if (v == -3) begin
          check("crc high", {8'h00, tx_byte}, {8'h00, crc[15:8]});
          crc = 16'hffff;
        end else check("byte", {8'h00, tx_byte}, 16'(v));
        n_bytes++;
      end
      lp_cnt = 0;
    end
  end

  // ----------------------------------------------------------------
  // stimulus: burst blanking line, pulse line with fill, event line
  // ----------------------------------------------------------------
  initial begin
    push4(32'h31000001, -1);
    push4(32'h080f0f01, 0);
    push4(32'h21000012, 1592);
    push4(32'h080f0f01, 0);
    // fill replaces the first hold, wc 1586 little endian
    push4(32'h31000001, 1716);
    push4(32'h1932065a, 0);
    for (int i = 0; i < 1586; i++) begin
      exp_q.push_back(-1);
      lp_q.push_back(0);
    end
    exp_q.push_back(-2);
    lp_q.push_back(0);
    exp_q.push_back(-3);
    lp_q.push_back(0);
    push4(32'h21000012, 0);
    push4(32'h080f0f01, 0);
    // event mode drops the sync end packet
    push4(32'h21000012, 1716 + 1592);
    push4(32'h080f0f01, 0);
    repeat (5) @(negedge core_clk);
    check("lp11 in reset", {15'h0000, tx_lp11}, 16'h0001);
    rstn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk);
      crc_cap = 1'($random(seed));
      corrupt = 1'($random(seed));
      value   = 16'($random(seed));
      send    = 1'b1;
      @(negedge core_clk);
      send = 1'b0;
      @(negedge core_clk);
      check("footer error", {15'h0000, rx_crc_err}, {15'h0000, crc_cap & corrupt});
    end
    wait (n_bytes >= 16);
    @(negedge core_clk);
    // a burst blanking line matches the plain one; the fill needs pulse mode
    fill_en    = 1'b1;
    video_mode = DVS_MODE_PULSE;
    wait (n_bytes >= 1620);
    @(negedge core_clk);
    fill_en    = 1'b0;
    video_mode = DVS_MODE_EVENT;
    wait (n_bytes >= 1628);
    repeat (20) @(negedge core_clk);
    end_sim();
  end

  // watchdog: about 66k cycles are needed, cut at 95k
  initial begin
    #9500000;
    num_errors++;
    $display("[ERR] run length expected done seen hang");
    end_sim();
  end
endmodule : dvs_sequencer_bench
